// file: epepo_pkg.sv
// Shared constants and types of the EEPROM program/erase/override sequencer
package epepo_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_STAT = 8'h00;
  localparam logic [7:0] OFS_IDX  = 8'h04;
  localparam logic [7:0] OFS_OPND = 8'h08;
  localparam logic [7:0] OFS_PFP  = 8'h0C;
  localparam logic [7:0] OFS_EEP  = 8'h10;
  localparam logic [7:0] OFS_PST  = 8'h14;
  // Status field positions
  localparam int B_COMMAND_COMPLETE_FLAG = 7;
  localparam int B_ACC  = 5;
  localparam int B_FPV  = 4;
  localparam int B_MG1  = 1;
  localparam int B_MG0  = 0;
  // EEPROM protection field layout
  localparam int B_EPEN = 7;
  localparam int EP_SHIFT = 5;
  // Command opcodes
  localparam logic [7:0] OP_PGM = 8'h11;
  localparam logic [7:0] OP_ERS = 8'h12;
  localparam logic [7:0] OP_OVR = 8'h13;
  // Operand index values
  localparam logic [2:0] IX_1 = 3'h1;
  localparam logic [2:0] IX_2 = 3'h2;
  localparam logic [2:0] IX_3 = 3'h3;
  localparam logic [2:0] IX_5 = 3'h5;
  localparam logic [15:0] KEY_ERASED = 16'hFFFF;
  localparam logic [7:0]  PROT_RST   = 8'h00;
  // Memory controller operations
  typedef enum logic [1:0] {
    MC_NONE  = 2'b00,
    MC_PGM   = 2'b01,
    MC_ERASE = 2'b10
  } epepo_mcop_e;
  // Request to the memory controller
  typedef struct packed {
    epepo_mcop_e op;
    logic [23:0] addr;
    logic [15:0] data;
  } epepo_mcreq_s;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CHECK = 3'b001,
    ST_MEM   = 3'b010,
    ST_DONE  = 3'b011
  } epepo_state_e;
endpackage

// file: epepo_top.sv
// APB-reached command sequencer for EEPROM program, sector erase and protection override
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module epepo_top #(
  parameter logic [23:0] EE_BASE  = 24'h100000,
  parameter int          EE_BYTES = 2048,
  parameter int          SEC_BYTES = 4
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  cmd_allowed,
  input  wire logic [15:0]           cfg_override_key,
  output epepo_pkg::epepo_mcreq_s    mc_req,
  output logic                       mc_valid,
  input  wire logic                  mc_done,
  input  wire logic                  mc_err_any,
  input  wire logic                  mc_err_fatal,
  output logic [7:0]                 pflash_protection_reg,
  output logic [7:0]                 eeprom_protection_reg
);
  localparam int AW = $clog2(EE_BYTES);
  // Sizes the offset arithmetic cannot serve are refused
  if (EE_BYTES < 16 || (EE_BYTES & (EE_BYTES - 1)) != 0) begin : g_bad_block
    $error("EE_BYTES must be a power of two of at least 16");
  end
  if (SEC_BYTES < 2 || (SEC_BYTES & (SEC_BYTES - 1)) != 0) begin : g_bad_sector
    $error("SEC_BYTES must be a power of two of at least 2");
  end
  if (SEC_BYTES > EE_BYTES) begin : g_bad_ratio
    $error("SEC_BYTES must not exceed EE_BYTES");
  end
  if ((EE_BASE & 24'(EE_BYTES - 1)) != 24'h0) begin : g_bad_base
    $error("EE_BASE must be block aligned");
  end

  epepo_pkg::epepo_state_e   state_r;
  logic                      command_complete_flag;
  logic                      access_error_flag;
  logic                      protection_violation_flag;
  logic                      verify_error_upper;
  logic                      verify_error_lower;
  logic                      override_active_bit;
  logic [2:0]                operand_index;
  logic [15:0]               command_operand_regs [0:5];
  logic [15:0]               save_buf_r;
  logic [2:0]                word_r;
  logic [2:0]                nwords_r;
  logic                      is_erase_r;

  // APB access decode
  logic wr_acc;
  logic rd_acc;
  logic hit;
  assign hit    = paddr inside {epepo_pkg::OFS_STAT, epepo_pkg::OFS_IDX, epepo_pkg::OFS_OPND,
                                epepo_pkg::OFS_PFP, epepo_pkg::OFS_EEP, epepo_pkg::OFS_PST};
  assign wr_acc = psel & penable & pwrite & hit;
  assign rd_acc = psel & penable & ~pwrite & hit;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Launch: write one to the complete bit while idle
  logic launch;
  assign launch = wr_acc && paddr == epepo_pkg::OFS_STAT && pwdata[epepo_pkg::B_COMMAND_COMPLETE_FLAG]
                  && command_complete_flag;

  // Decoded command fields
  logic [7:0]    opc;
  logic [23:0]   gaddr;
  logic [AW-1:0] off;
  logic [2:0]    nwords;
  logic          in_block;
  logic          ee_prot;
  logic [AW:0]   prot_lim;
  logic [AW:0]   last_off;
  assign opc      = command_operand_regs[0][15:8];
  assign gaddr    = {command_operand_regs[0][7:0], command_operand_regs[1]};
  assign in_block = (gaddr & ~24'(EE_BYTES - 1)) == EE_BASE;
  assign off      = gaddr[AW-1:0];
  assign nwords   = operand_index - epepo_pkg::IX_1;
  assign last_off = {1'b0, off} + {{(AW-3){1'b0}}, nwords, 1'b0};
  assign prot_lim = (AW+1)'({eeprom_protection_reg[5:0], 5'h00}) + (AW+1)'(1 << epepo_pkg::EP_SHIFT);
  // Protected region grows upward from the block start
  assign ee_prot  = eeprom_protection_reg[epepo_pkg::B_EPEN] && {1'b0, off} < prot_lim;

  // Override key evaluation
  logic [1:0] sel;
  logic       key_ok;
  logic       restore;
  assign sel     = command_operand_regs[0][1:0];
  assign key_ok  = command_operand_regs[1] != epepo_pkg::KEY_ERASED
                   && cfg_override_key != epepo_pkg::KEY_ERASED
                   && command_operand_regs[1] == cfg_override_key;
  assign restore = ~key_ok;

  // Launch checks, evaluated in the check state
  logic acc_err;
  logic prot_err;
  always_comb begin
    acc_err  = ~cmd_allowed;
    prot_err = 1'b0;
    case (opc)
      epepo_pkg::OP_PGM: begin
        if (operand_index < epepo_pkg::IX_2 || operand_index > epepo_pkg::IX_5) begin
          acc_err = 1'b1;
        end
        if (!in_block || gaddr[0]) begin
          acc_err = 1'b1;
        end
        // The group may end exactly at the block end
        if (last_off > (AW+1)'(EE_BYTES)) begin
          acc_err = 1'b1;
        end
        prot_err = ee_prot;
      end
      epepo_pkg::OP_ERS: begin
        if (operand_index != epepo_pkg::IX_1 || !in_block || gaddr[0]) begin
          acc_err = 1'b1;
        end
        prot_err = ee_prot;
      end
      epepo_pkg::OP_OVR: begin
        if (!(operand_index inside {epepo_pkg::IX_1, epepo_pkg::IX_2, epepo_pkg::IX_3})) begin
          acc_err = 1'b1;
        end
        if (restore && !override_active_bit) begin
          acc_err = 1'b1;
        end
        if (sel == 2'b00 && (operand_index != epepo_pkg::IX_1 || key_ok)) begin
          acc_err = 1'b1;
        end
      end
      default: acc_err = 1'b1;
    endcase
  end

  // Sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= epepo_pkg::ST_IDLE;
      word_r     <= 3'h0;
      nwords_r   <= 3'h0;
      is_erase_r <= 1'b0;
    end else begin
      case (state_r)
        epepo_pkg::ST_IDLE: begin
          if (launch) begin
            state_r <= epepo_pkg::ST_CHECK;
          end
        end
        epepo_pkg::ST_CHECK: begin
          // Latch word count; clean program and erase launches go to memory, overrides go to done
          word_r     <= 3'h0;
          nwords_r   <= nwords;
          is_erase_r <= opc == epepo_pkg::OP_ERS;
          if (acc_err || prot_err || opc == epepo_pkg::OP_OVR) begin
            state_r <= epepo_pkg::ST_DONE;
          end else begin
            state_r <= epepo_pkg::ST_MEM;
          end
        end
        epepo_pkg::ST_MEM: begin
          if (mc_done) begin
            word_r <= word_r + 3'h1;
            if (is_erase_r || word_r + 3'h1 == nwords_r) begin
              state_r <= epepo_pkg::ST_DONE;
            end
          end
        end
        epepo_pkg::ST_DONE: state_r <= epepo_pkg::ST_IDLE;
        default: state_r <= epepo_pkg::ST_IDLE;
      endcase
    end
  end

  // Request the sequencer wants to present next
  epepo_pkg::epepo_mcreq_s req_nxt;
  always_comb begin
    req_nxt.op   = epepo_pkg::MC_PGM;
    req_nxt.addr = gaddr + {20'h0, word_r, 1'b0};
    req_nxt.data = command_operand_regs[epepo_pkg::IX_2 + word_r];
    if (is_erase_r) begin
      req_nxt.op   = epepo_pkg::MC_ERASE;
      req_nxt.addr = gaddr & ~24'(SEC_BYTES - 1);
    end
  end

  // Registered request, reloaded every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_req <= '0;
    end else begin
      mc_req <= req_nxt;
    end
  end
  // Valid only once the whole registered request matches, so a stale
  // operation or address left by the previous command is never offered
  assign mc_valid = state_r == epepo_pkg::ST_MEM && mc_req == req_nxt;

  // Complete flag: cleared by launch, set on leaving the done state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_complete_flag <= 1'b1;
    end else if (launch) begin
      command_complete_flag <= 1'b0;
    end else if (state_r == epepo_pkg::ST_DONE) begin
      command_complete_flag <= 1'b1;
    end
  end

  // Error flags: write one to clear while idle; the launch check sets them
  logic err_clr;
  assign err_clr = wr_acc && paddr == epepo_pkg::OFS_STAT && command_complete_flag;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_error_flag <= 1'b0;
    end else if (state_r == epepo_pkg::ST_CHECK && acc_err) begin
      access_error_flag <= 1'b1;
    end else if (err_clr && pwdata[epepo_pkg::B_ACC]) begin
      access_error_flag <= 1'b0;
    end
  end
  // Access error masks a protection violation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protection_violation_flag <= 1'b0;
    end else if (state_r == epepo_pkg::ST_CHECK && prot_err && !acc_err) begin
      protection_violation_flag <= 1'b1;
    end else if (err_clr && pwdata[epepo_pkg::B_FPV]) begin
      protection_violation_flag <= 1'b0;
    end
  end

  // Verify results: cleared by launch, gathered at each memory done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      verify_error_upper <= 1'b0;
      verify_error_lower <= 1'b0;
    end else if (launch) begin
      verify_error_upper <= 1'b0;
      verify_error_lower <= 1'b0;
    end else if (state_r == epepo_pkg::ST_MEM && mc_done) begin
      if (mc_err_any) verify_error_upper <= 1'b1;
      if (mc_err_fatal) verify_error_lower <= 1'b1;
    end
  end

  // Override launch that passed its checks
  logic ovr_go;
  assign ovr_go = state_r == epepo_pkg::ST_CHECK && opc == epepo_pkg::OP_OVR && !acc_err;

  // P-Flash protection: restore, override, else direct writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pflash_protection_reg <= epepo_pkg::PROT_RST;
    end else if (ovr_go && restore) begin
      pflash_protection_reg <= save_buf_r[15:8];
    end else if (ovr_go && sel[0]) begin
      pflash_protection_reg <= command_operand_regs[2][7:0];
    end else if (!ovr_go && wr_acc && paddr == epepo_pkg::OFS_PFP) begin
      pflash_protection_reg <= pwdata[7:0];
    end
  end

  // EEPROM protection: same priorities as the P-Flash register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eeprom_protection_reg <= epepo_pkg::PROT_RST;
    end else if (ovr_go && restore) begin
      eeprom_protection_reg <= save_buf_r[7:0];
    end else if (ovr_go && sel[1]) begin
      eeprom_protection_reg <= command_operand_regs[3][7:0];
    end else if (!ovr_go && wr_acc && paddr == epepo_pkg::OFS_EEP) begin
      eeprom_protection_reg <= pwdata[7:0];
    end
  end

  // Single-entry buffer, refilled by every granted override whose key matches (not by a restore)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      save_buf_r <= {epepo_pkg::PROT_RST, epepo_pkg::PROT_RST};
    end else if (ovr_go && !restore) begin
      save_buf_r <= {pflash_protection_reg, eeprom_protection_reg};
    end
  end

  // Override-active bit follows the outcome of the last granted override
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      override_active_bit <= 1'b0;
    end else if (ovr_go) begin
      override_active_bit <= !restore;
    end
  end

  // Index and operand registers, writable only while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand_index <= 3'h0;
      for (int i = 0; i < 6; i++) command_operand_regs[i] <= 16'h0000;
    end else if (wr_acc && command_complete_flag) begin
      if (paddr == epepo_pkg::OFS_IDX) operand_index <= pwdata[2:0];
      if (paddr == epepo_pkg::OFS_OPND && operand_index <= epepo_pkg::IX_5) begin
        command_operand_regs[operand_index] <= pwdata[15:0];
      end
    end
  end

  // Status byte built at the flag positions
  logic [7:0] status_byte;
  always_comb begin
    status_byte                    = 8'h00;
    status_byte[epepo_pkg::B_COMMAND_COMPLETE_FLAG] = command_complete_flag;
    status_byte[epepo_pkg::B_ACC]  = access_error_flag;
    status_byte[epepo_pkg::B_FPV]  = protection_violation_flag;
    status_byte[epepo_pkg::B_MG1]  = verify_error_upper;
    status_byte[epepo_pkg::B_MG0]  = verify_error_lower;
  end

  // Read data mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        epepo_pkg::OFS_STAT: prdata <= {24'h0, status_byte};
        epepo_pkg::OFS_IDX:  prdata <= {29'h0, operand_index};
        epepo_pkg::OFS_OPND: prdata <= operand_index <= epepo_pkg::IX_5
                                       ? {16'h0, command_operand_regs[operand_index]} : 32'h0;
        epepo_pkg::OFS_PFP:  prdata <= {24'h0, pflash_protection_reg};
        epepo_pkg::OFS_EEP:  prdata <= {24'h0, eeprom_protection_reg};
        epepo_pkg::OFS_PST:  prdata <= {31'h0, override_active_bit};
        default:             prdata <= 32'h0;
      endcase
    end
  end
  logic unused_rd;
  assign unused_rd = rd_acc;
endmodule // epepo_top

// file: epepo_top_checker.sv
// Port assertions for the command sequencer
`timescale 1ns/100ps
module epepo_chk #(
  parameter logic [23:0] EE_BASE   = 24'h100000,
  parameter int          EE_BYTES  = 2048,
  parameter int          SEC_BYTES = 4
) (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pslverr,
  input wire logic                    cmd_allowed,
  input wire epepo_pkg::epepo_mcreq_s mc_req,
  input wire logic                    mc_valid,
  input wire logic                    mc_done,
  input wire logic [7:0]              pflash_protection_reg,
  input wire logic [7:0]              eeprom_protection_reg
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus decode seen from outside
  wire acc  = psel && penable;
  wire lnch = acc && pwrite && paddr == epepo_pkg::OFS_STAT && pwdata[epepo_pkg::B_COMMAND_COMPLETE_FLAG];
  wire wpr  = acc && pwrite && paddr inside {epepo_pkg::OFS_PFP, epepo_pkg::OFS_EEP};
  wire map  = paddr inside {epepo_pkg::OFS_STAT, epepo_pkg::OFS_IDX, epepo_pkg::OFS_OPND,
                            epepo_pkg::OFS_PFP, epepo_pkg::OFS_EEP, epepo_pkg::OFS_PST};
  logic [2:0] since_r;
  // Cycles since the last launch, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_r <= 3'h7;
    else if (lnch) since_r <= 3'h0;
    else if (since_r != 3'h7) since_r <= since_r + 3'h1;
  end
  sequence s_bad_launch;
    lnch && !cmd_allowed && !mc_valid;
  endsequence
  sequence s_no_mem;
    !mc_valid [*4];
  endsequence
  a_refused_launch: assert property (s_bad_launch |=> s_no_mem)
    else $error("memory request after refused launch");
  a_req_held: assert property (mc_valid && !mc_done |=> mc_valid && $stable(mc_req))
    else $error("request dropped or changed before done");
  a_op_legal: assert property (mc_valid |->
    mc_req.op inside {epepo_pkg::MC_PGM, epepo_pkg::MC_ERASE}) else $error("bad memory op");
  a_addr_even: assert property (mc_valid |-> !mc_req.addr[0])
    else $error("odd memory address");
  a_addr_inside: assert property (mc_valid |->
    mc_req.addr >= EE_BASE && mc_req.addr < EE_BASE + EE_BYTES) else $error("address outside block");
  a_sector_base: assert property (mc_valid && mc_req.op == epepo_pkg::MC_ERASE |->
    (mc_req.addr % SEC_BYTES) == 0) else $error("erase not sector aligned");
  a_prot_cause: assert property ($changed({pflash_protection_reg, eeprom_protection_reg}) |->
    $past(wpr) || since_r < 3'h5) else $error("protection changed without cause");
  a_slverr_map: assert property (acc |-> pslverr == !map)
    else $error("pslverr does not match address map");
endmodule // epepo_chk

bind epepo_top epepo_chk #(.EE_BASE(EE_BASE), .EE_BYTES(EE_BYTES), .SEC_BYTES(SEC_BYTES)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .cmd_allowed,
  .mc_req, .mc_valid, .mc_done, .pflash_protection_reg, .eeprom_protection_reg);

// file: epepo_mem_model.sv
// Memory controller stand-in answering sequencer requests
`timescale 1ns/100ps
module epepo_mem_model (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    mc_valid,
  input  wire epepo_pkg::epepo_mcreq_s mc_req,
  input  wire logic [3:0]              lat,
  input  wire logic [1:0]              verr,
  output logic                         mc_done,
  output logic                         mc_err_any,
  output logic                         mc_err_fatal
);
  logic [3:0]              cnt_r;
  logic                    tog_r;
  int                      n_req;
  epepo_pkg::epepo_mcreq_s rec [64];
  // Finish a held request after lat cycles, logging it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= 4'h0;
      mc_done <= 1'b0;
      n_req   <= 0;
    end else if (mc_done) begin
      mc_done <= 1'b0;
    end else if (mc_valid && cnt_r >= lat) begin
      mc_done         <= 1'b1;
      cnt_r           <= 4'h0;
      rec[n_req[5:0]] <= mc_req;
      n_req           <= n_req + 1;
    end else if (mc_valid) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  // Churn pattern when no result is offered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tog_r <= 1'b0;
    else tog_r <= !tog_r;
  end
  // Verify results valid only beside done
  assign mc_err_any   = mc_done ? verr[1] : tog_r;
  assign mc_err_fatal = mc_done ? verr[0] : !tog_r;
endmodule // epepo_mem_model

// file: epepo_top_bench.sv
// Self-checking bench for the command sequencer
`timescale 1ns/100ps
module epepo_top_bench;
  logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic                    cmd_allowed, mc_valid, mc_done, mc_err_any, mc_err_fatal;
  logic [7:0]              paddr, pfp, eep;
  logic [31:0]             pwdata, prdata, rd;
  logic [15:0]             cfg_key, a16, d16;
  logic [3:0]              lat;
  logic [1:0]              verr;
  epepo_pkg::epepo_mcreq_s mc_req;
  int                      n_fail, tests_run, n0;
  logic [15:0]             eo [10] = '{16'h1110, 16'h1110, 16'h1120, 16'h1110, 16'h1210,
                                       16'h1210, 16'h1110, 16'h1110, 16'h1110, 16'h1110};
  logic [15:0]             ea [10] = '{16'h0011, 16'h07FC, 16'h0000, 16'h0010, 16'h0011,
                                       16'h0010, 16'h0010, 16'h0010, 16'h0010, 16'h0010};
  logic [2:0]              ei [10] = '{3'h5, 3'h5, 3'h2, 3'h2, 3'h1, 3'h2, 3'h0, 3'h1, 3'h6, 3'h7};
  epepo_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cmd_allowed, .cfg_override_key(cfg_key), .mc_req, .mc_valid, .mc_done,
    .mc_err_any, .mc_err_fatal, .pflash_protection_reg(pfp), .eeprom_protection_reg(eep));
  epepo_mem_model mem (.pclk, .presetn, .mc_valid, .mc_req, .lat, .verr, .mc_done,
    .mc_err_any, .mc_err_fatal);
  // Clock source
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_fail++;
      end_sim();
    end
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Load operands, set index, launch, wait for completion, check status
  task automatic cmd(input logic [0:5][15:0] o, input logic [2:0] ix, input logic [7:0] e);
    int k;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, epepo_pkg::OFS_IDX, 32'(i));
      apb(1'b1, epepo_pkg::OFS_OPND, {16'h0, o[i]});
    end
    apb(1'b1, epepo_pkg::OFS_IDX, {29'h0, ix});
    apb(1'b1, epepo_pkg::OFS_STAT, 32'h00000080);
    k = 0;
    do begin
      apb(1'b0, epepo_pkg::OFS_STAT, 32'h0);
      k++;
    end while (rd[7] !== 1'b1 && k < 40);
    if (k >= 40) begin
      n_fail++;
      end_sim();
    end
    chk("status", {24'h0, e}, rd);
    apb(1'b1, epepo_pkg::OFS_STAT, 32'h00000030);
  endtask
  // Override command with protection and override-bit checks
  task automatic ovr(input logic [0:3][15:0] o, input logic [2:0] ix, input logic [7:0] e,
                     input logic [7:0] ep, input logic [7:0] ee, input logic ps);
    cmd({o, 32'h0}, ix, e);
    chk("pflash prot", {24'h0, ep}, {24'h0, pfp});
    chk("eeprom prot", {24'h0, ee}, {24'h0, eep});
    apb(1'b0, epepo_pkg::OFS_PST, 32'h0);
    chk("override bit", {31'h0, ps}, {31'h0, rd[0]});
  endtask
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, verr, lat} = '0;
    cmd_allowed = 1'b1;
    cfg_key     = 16'h1234;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (eo[i]) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset read", (i == 0) ? 32'h80 : 32'h0, rd);
      chk("pslverr", {31'h0, i >= 6}, {31'h0, se});
    end
    // Fresh words per group, latency varied
    for (int ix = 2; ix <= 5; ix++) begin
      n0  = mem.n_req;
      lat <= 4'(ix * 2 - 4);
      a16 = 16'(ix * 32);
      d16 = 16'hD000 + 16'(ix * 16);
      cmd({16'h1110, a16, d16, d16 + 16'h1, d16 + 16'h2, d16 + 16'h3}, 3'(ix), 8'h80);
      chk("word count", n0 + ix - 1, mem.n_req);
      for (int k = 0; k < ix - 1; k++) begin
        chk("word addr", {8'h10, a16 + 16'(2 * k)}, {8'h0, mem.rec[n0 + k].addr});
        chk("word data", {16'h0, d16 + 16'(k)}, {16'h0, mem.rec[n0 + k].data});
      end
    end
    cmd({16'h1110, 16'h07FE, 16'hBEEF, 48'h0}, 3'h2, 8'h80);
    chk("last word", 32'h1007FE, {8'h0, mem.rec[mem.n_req - 1].addr});
    n0 = mem.n_req;
    foreach (eo[i]) begin
      cmd_allowed <= (i != 3);
      cmd({eo[i], ea[i], 64'h0}, ei[i], 8'hA0);
    end
    cmd_allowed <= 1'b1;
    cmd({16'h1410, 16'h0010, 64'h0}, 3'h1, 8'hA0);
    chk("no request", n0, mem.n_req);
    verr <= 2'b11;
    cmd({16'h1210, 16'h0106, 64'h0}, 3'h1, 8'h83);
    chk("erase addr", 32'h100104, {8'h0, mem.rec[n0].addr});
    chk("erase op", {30'h0, epepo_pkg::MC_ERASE}, {30'h0, mem.rec[n0].op});
    verr <= 2'b10;
    cmd({16'h1110, 16'h0300, 16'h1234, 48'h0}, 3'h2, 8'h82);
    verr <= 2'b00;
    apb(1'b1, epepo_pkg::OFS_EEP, 32'h80);
    n0 = mem.n_req;
    cmd({16'h1110, 16'h0000, 64'h0}, 3'h2, 8'h90);
    cmd({16'h1210, 16'h0010, 64'h0}, 3'h1, 8'h90);
    chk("no request", n0, mem.n_req);
    ovr({16'h1300, 16'h1234, 32'h0}, 3'h1, 8'hA0, 8'h00, 8'h80, 1'b0);
    ovr({16'h1303, 16'h5555, 32'h0}, 3'h1, 8'hA0, 8'h00, 8'h80, 1'b0);
    ovr({16'h1303, 16'h1234, 16'h55, 16'h0}, 3'h3, 8'h80, 8'h55, 8'h00, 1'b1);
    apb(1'b1, epepo_pkg::OFS_PFP, 32'h77);
    ovr({16'h1303, 16'hFFFF, 32'h0}, 3'h1, 8'h80, 8'h00, 8'h80, 1'b0);
    ovr({16'h1301, 16'h1234, 16'h11, 16'h22}, 3'h3, 8'h80, 8'h11, 8'h80, 1'b1);
    ovr({16'h1303, 16'h1234, 32'h0}, 3'h4, 8'hA0, 8'h11, 8'h80, 1'b1);
    ovr({16'h1300, 16'h1234, 32'h0}, 3'h2, 8'hA0, 8'h11, 8'h80, 1'b1);
    cfg_key <= 16'hFFFF;
    ovr({16'h1303, 16'hFFFF, 32'h0}, 3'h3, 8'h80, 8'h00, 8'h80, 1'b0);
    ovr({16'h1303, 16'h1234, 32'h0}, 3'h3, 8'hA0, 8'h00, 8'h80, 1'b0);
    end_sim();
  end
endmodule // epepo_top_bench
